// ---- core/tws_master_ctrl.sv ----
// two-wire bus master controller with wishbone register port
`timescale 1ns/1ps

module tws_master_ctrl (
  input  wire logic                  clk_i,    // system clock 100 MHz
  input  wire logic                  rst_n_i,  // sync reset, active low
  input  wire tws_pkg::tws_wb_req_t  wb_req_i, // wishbone request
  output tws_pkg::tws_wb_rsp_t       wb_rsp_o, // wishbone answer
  input  wire tws_pkg::tws_pin_in_t  pin_i,    // bus line levels
  output tws_pkg::tws_pin_out_t      pin_o     // bus line drivers
);
  import tws_pkg::*;

  logic              scl_f;
  logic              sda_f;
  logic              start_seen;
  logic              stop_seen;
  logic              tick;
  logic              run;
  logic              stall;
  logic              busy;
  logic              bus_free;
  logic              wb_req;
  logic              wb_wr;
  logic              cmd_load;
  logic [STAT_W-1:0] stat;
  logic [STAT_W-1:0] stat_clr;

  tws_state_t        st_q;
  logic [1:0]        ph_q;
  logic [3:0]        bit_q;
  logic [CMD_W-1:0]  pend_q;
  logic              nack_q;
  logic              rd_mode_q;
  logic              first_q;
  logic              own_q;
  logic [7:0]        txs_q;
  logic [7:0]        rxs_q;
  logic [7:0]        rxd_q;
  logic [7:0]        ctrl_q;
  logic [7:0]        txd_q;
  logic              rx_nack_q;
  logic              arb_addr_q;
  logic              arb_data_q;
  logic              done_q;
  logic              refused_q;
  logic              scl_oe_n_q;
  logic              sda_oe_n_q;
  logic              low_q;
  logic              ack_q;
  logic [31:0]       rdat_q;

  // ****************************************************************
  // line conditioning and bit timing
  // ****************************************************************
  tws_line_sync u_sync (
    .clk_i        (clk_i),
    .rst_n_i      (rst_n_i),
    .en_i         (ctrl_q[CTRL_EN]),
    .pin_i        (pin_i),
    .scl_o        (scl_f),
    .sda_o        (sda_f),
    .start_seen_o (start_seen),
    .stop_seen_o  (stop_seen)
  );

  // the clock line may be held low by the far side; wait for it high
  assign stall = (ph_q == 2'd2) && !scl_f;
  assign run   = (st_q != ST_IDLE) && !stall;

  tws_quarter_tick u_tick (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .run_i   (run),
    .tick_o  (tick)
  );

  // ****************************************************************
  // register decode
  // ****************************************************************
  function automatic logic hit(input logic [7:0] adr, input logic [7:0] ofs);
    return adr == ofs;
  endfunction

  assign wb_req   = wb_req_i.cyc && wb_req_i.stb && !ack_q;
  assign wb_wr    = wb_req && wb_req_i.we && wb_req_i.sel[0];
  assign busy     = (st_q != ST_IDLE) || (|pend_q);
  assign cmd_load = wb_wr && hit(wb_req_i.adr, REG_CMD) && !busy;
  assign bus_free = (stop_seen || (!start_seen && !stop_seen)) && scl_f && sda_f;
  assign stat_clr = (wb_wr && hit(wb_req_i.adr, REG_STAT)) ? wb_req_i.dat[STAT_W-1:0] : '0;

  always_comb begin
    stat                = '0;
    stat[STAT_BUSY]     = busy;
    stat[STAT_START_SN] = start_seen;
    stat[STAT_STOP_SN]  = stop_seen;
    stat[STAT_OWN]      = own_q;
    stat[STAT_RX_NACK]  = rx_nack_q;
    stat[STAT_ARB_ADDR] = arb_addr_q;
    stat[STAT_ARB_DATA] = arb_data_q;
    stat[STAT_DONE]     = done_q;
    stat[STAT_REFUSED]  = refused_q;
  end

  // ****************************************************************
  // wishbone slave
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ack_q  <= 1'b0;
      rdat_q <= '0;
    end else begin
      ack_q <= wb_req;
      if (wb_req) begin
        rdat_q <= '0;
        if (hit(wb_req_i.adr, REG_CTRL)) begin
          rdat_q[7:0] <= ctrl_q;
        end else if (hit(wb_req_i.adr, REG_TXD)) begin
          rdat_q[7:0] <= txd_q;
        end else if (hit(wb_req_i.adr, REG_RXD)) begin
          rdat_q[7:0] <= rxd_q;
        end else if (hit(wb_req_i.adr, REG_STAT)) begin
          rdat_q[STAT_W-1:0] <= stat;
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ctrl_q <= CTRL_RST;
      txd_q  <= TXD_RST;
    end else if (wb_wr) begin
      if (hit(wb_req_i.adr, REG_CTRL)) begin
        ctrl_q <= {7'h00, wb_req_i.dat[CTRL_EN]};
      end
      if (hit(wb_req_i.adr, REG_TXD) && !busy) begin
        txd_q <= wb_req_i.dat[7:0];
      end
    end
  end

  // ****************************************************************
  // bus sequencer
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || !ctrl_q[CTRL_EN]) begin
      st_q       <= ST_IDLE;
      ph_q       <= 2'd0;
      bit_q      <= 4'h0;
      pend_q     <= '0;
      nack_q     <= 1'b0;
      rd_mode_q  <= 1'b0;
      first_q    <= 1'b0;
      own_q      <= 1'b0;
      txs_q      <= 8'h00;
      rxs_q      <= 8'h00;
      rxd_q      <= 8'h00;
      rx_nack_q  <= 1'b0;
      arb_addr_q <= 1'b0;
      arb_data_q <= 1'b0;
      done_q     <= 1'b0;
      refused_q  <= 1'b0;
      scl_oe_n_q <= 1'b1;
      sda_oe_n_q <= 1'b1;
    end else begin
      // software clears first so that a set in the same cycle wins
      if (stat_clr[STAT_RX_NACK]) rx_nack_q <= 1'b0;
      if (stat_clr[STAT_ARB_ADDR]) arb_addr_q <= 1'b0;
      if (stat_clr[STAT_ARB_DATA]) arb_data_q <= 1'b0;
      if (stat_clr[STAT_DONE]) done_q <= 1'b0;
      if (stat_clr[STAT_REFUSED]) refused_q <= 1'b0;
      if (cmd_load) begin
        pend_q <= wb_req_i.dat[CMD_W-1:0];
        nack_q <= wb_req_i.dat[CMD_NACK];
      end
      if (tick) begin
        ph_q <= ph_q + 2'd1;
      end
      case (st_q)
        ST_IDLE: begin
          ph_q <= 2'd0;
          if (pend_q[CMD_START]) begin
            pend_q[CMD_START] <= 1'b0;
            if (own_q || bus_free) begin
              st_q <= ST_START;
            end else begin
              pend_q    <= '0;
              refused_q <= 1'b1;
            end
          end else if (pend_q[CMD_WRITE] || pend_q[CMD_READ]) begin
            pend_q[CMD_WRITE] <= 1'b0;
            pend_q[CMD_READ]  <= 1'b0;
            if (own_q) begin
              st_q      <= ST_BIT;
              bit_q     <= 4'h0;
              rd_mode_q <= !pend_q[CMD_WRITE];
              txs_q     <= txd_q;
            end else begin
              pend_q    <= '0;
              refused_q <= 1'b1;
            end
          end else if (pend_q[CMD_STOP]) begin
            pend_q[CMD_STOP] <= 1'b0;
            if (own_q) begin
              st_q <= ST_STOP;
            end else begin
              refused_q <= 1'b1;
            end
          end
        end
        ST_START: begin
          if (tick) begin
            case (ph_q)
              2'd0: sda_oe_n_q <= 1'b1;
              2'd1: scl_oe_n_q <= 1'b1;
              2'd2: sda_oe_n_q <= 1'b0;
              default: begin
                scl_oe_n_q <= 1'b0;
                own_q      <= 1'b1;
                first_q    <= 1'b1;
                st_q       <= ST_IDLE;
              end
            endcase
          end
        end
        ST_BIT: begin
          if (tick) begin
            case (ph_q)
              2'd0: begin
                if (bit_q != 4'd8) begin
                  sda_oe_n_q <= rd_mode_q ? 1'b1 : txs_q[7];
                end else begin
                  sda_oe_n_q <= rd_mode_q ? nack_q : 1'b1;
                end
              end
              2'd1: scl_oe_n_q <= 1'b1;
              2'd2: begin
                if (bit_q != 4'd8) begin
                  rxs_q <= {rxs_q[6:0], sda_f};
                  txs_q <= {txs_q[6:0], 1'b0};
                  if (!rd_mode_q && sda_oe_n_q && !sda_f) begin
                    scl_oe_n_q <= 1'b1;
                    sda_oe_n_q <= 1'b1;
                    own_q      <= 1'b0;
                    pend_q     <= '0;
                    st_q       <= ST_IDLE;
                    arb_addr_q <= first_q || arb_addr_q;
                    arb_data_q <= !first_q || arb_data_q;
                  end
                end else if (!rd_mode_q) begin
                  rx_nack_q <= sda_f;
                end
              end
              default: begin
                scl_oe_n_q <= 1'b0;
                if (bit_q == 4'd8) begin
                  st_q    <= ST_IDLE;
                  done_q  <= 1'b1;
                  first_q <= 1'b0;
                  if (rd_mode_q) begin
                    rxd_q <= rxs_q;
                  end
                end else begin
                  bit_q <= bit_q + 4'h1;
                end
              end
            endcase
          end
        end
        ST_STOP: begin
          if (tick) begin
            case (ph_q)
              2'd0: sda_oe_n_q <= 1'b0;
              2'd1: scl_oe_n_q <= 1'b1;
              2'd2: sda_oe_n_q <= 1'b1;
              default: begin
                own_q  <= 1'b0;
                done_q <= 1'b1;
                st_q   <= ST_IDLE;
              end
            endcase
          end
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    low_q <= 1'b0;
  end

  assign wb_rsp_o.ack = ack_q;
  assign wb_rsp_o.dat = rdat_q;
  assign pin_o.scl_o    = low_q;
  assign pin_o.scl_oe_n = scl_oe_n_q;
  assign pin_o.sda_o    = low_q;
  assign pin_o.sda_oe_n = sda_oe_n_q;

endmodule

// ---- core/tws_pkg.sv ----
// constants, register map and carrier types of the two-wire bus master
package tws_pkg;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned BIT_RATE_KBPS = 100;
  localparam int unsigned BIT_PERIOD_NS = 1000000 / BIT_RATE_KBPS;
  localparam int unsigned QUARTER_NS    = BIT_PERIOD_NS / 4;
  localparam int unsigned QUARTER_CYC   = (QUARTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned QCNT_W        = 9;
  localparam logic [QCNT_W-1:0] QCNT_LAST = QCNT_W'(QUARTER_CYC - 1);

  // ****************************************************************
  // own registers, byte addresses on the bus
  // ****************************************************************
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_CMD  = 8'h04;
  localparam logic [7:0] REG_TXD  = 8'h08;
  localparam logic [7:0] REG_RXD  = 8'h0C;
  localparam logic [7:0] REG_STAT = 8'h10;

  localparam int unsigned CTRL_EN   = 0;
  localparam int unsigned CMD_START = 0;
  localparam int unsigned CMD_WRITE = 1;
  localparam int unsigned CMD_READ  = 2;
  localparam int unsigned CMD_STOP  = 3;
  localparam int unsigned CMD_NACK  = 4;
  localparam int unsigned CMD_W     = 4;

  localparam int unsigned STAT_BUSY     = 0;
  localparam int unsigned STAT_START_SN = 1;
  localparam int unsigned STAT_STOP_SN  = 2;
  localparam int unsigned STAT_OWN      = 3;
  localparam int unsigned STAT_RX_NACK  = 4;
  localparam int unsigned STAT_ARB_ADDR = 5;
  localparam int unsigned STAT_ARB_DATA = 6;
  localparam int unsigned STAT_DONE     = 7;
  localparam int unsigned STAT_REFUSED  = 8;
  localparam int unsigned STAT_W        = 9;

  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] TXD_RST  = 8'h00;

  // ****************************************************************
  // register map of the port on the far side (reference only)
  // ****************************************************************
  localparam logic [7:0] DEV_IRQ_FLAG_REG     = 8'h0C;
  localparam logic [7:0] DEV_SERIAL_BUF_REG   = 8'h13;
  localparam logic [7:0] DEV_SERIAL_CTRL_REG  = 8'h14;
  localparam logic [7:0] DEV_PORT_C_DIR_REG   = 8'h87;
  localparam logic [7:0] DEV_IRQ_ENABLE_REG   = 8'h8C;
  localparam logic [7:0] DEV_SERIAL_ADDR_REG  = 8'h93;
  localparam logic [7:0] DEV_SERIAL_STAT_REG  = 8'h94;
  localparam logic [7:0] DEV_PORT_C_DIR_RST   = 8'h3F;
  localparam logic [3:0] DEV_MODE_SLAVE_IDLE  = 4'hB;

  // ****************************************************************
  // carrier types
  // ****************************************************************
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } tws_wb_req_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } tws_wb_rsp_t;

  typedef struct packed {
    logic scl;
    logic sda;
  } tws_pin_in_t;

  typedef struct packed {
    logic scl_o;
    logic scl_oe_n;
    logic sda_o;
    logic sda_oe_n;
  } tws_pin_out_t;

  typedef enum logic [1:0] {ST_IDLE, ST_START, ST_BIT, ST_STOP} tws_state_t;

endpackage

// ---- core/tws_line_sync.sv ----
// bus line synchroniser with start and stop condition detection
`timescale 1ns/1ps
module tws_line_sync (
  input  wire logic              clk_i,        // system clock
  input  wire logic              rst_n_i,      // sync reset, active low
  input  wire logic              en_i,         // block enabled
  input  wire tws_pkg::tws_pin_in_t pin_i,     // raw bus lines
  output logic                   scl_o,        // filtered clock line
  output logic                   sda_o,        // filtered data line
  output logic                   start_seen_o, // start seen since last stop
  output logic                   stop_seen_o   // stop seen since last start
);
  import tws_pkg::*;

  logic [1:0] s1_q;
  logic [1:0] s2_q;
  logic [1:0] s3_q;
  logic [1:0] lvl_q;
  logic       start_det;
  logic       stop_det;

  // ****************************************************************
  // three flops, level changes once second and third agree
  // ****************************************************************
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_line
      always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
          s1_q[g]  <= 1'b1;
          s2_q[g]  <= 1'b1;
          s3_q[g]  <= 1'b1;
          lvl_q[g] <= 1'b1;
        end else begin
          s1_q[g] <= (g == 0) ? pin_i.sda : pin_i.scl;
          s2_q[g] <= s1_q[g];
          s3_q[g] <= s2_q[g];
          if (s2_q[g] == s3_q[g]) begin
            lvl_q[g] <= s3_q[g];
          end
        end
      end
    end
  endgenerate

  assign sda_o = lvl_q[0];
  assign scl_o = lvl_q[1];

  assign start_det = lvl_q[1] && (s2_q[1] == s3_q[1]) && s3_q[1] && lvl_q[0] && (s2_q[0] == s3_q[0]) && !s3_q[0];
  assign stop_det  = lvl_q[1] && (s2_q[1] == s3_q[1]) && s3_q[1] && !lvl_q[0] && (s2_q[0] == s3_q[0]) && s3_q[0];

  // ****************************************************************
  // bus state bits
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || !en_i) begin
      start_seen_o <= 1'b0;
      stop_seen_o  <= 1'b0;
    end else if (start_det) begin
      start_seen_o <= 1'b1;
      stop_seen_o  <= 1'b0;
    end else if (stop_det) begin
      start_seen_o <= 1'b0;
      stop_seen_o  <= 1'b1;
    end
  end

endmodule

// ---- core/tws_quarter_tick.sv ----
// quarter bit period tick generator
`timescale 1ns/1ps
module tws_quarter_tick (
  input  wire logic clk_i,   // system clock
  input  wire logic rst_n_i, // sync reset, active low
  input  wire logic run_i,   // count while high, restart when low
  output logic      tick_o   // one-cycle pulse each quarter bit
);
  import tws_pkg::*;

  logic [QCNT_W-1:0] cnt_q;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i || !run_i) begin
      cnt_q  <= '0;
      tick_o <= 1'b0;
    end else if (cnt_q == QCNT_LAST) begin
      cnt_q  <= '0;
      tick_o <= 1'b1;
    end else begin
      cnt_q  <= cnt_q + 1'b1;
      tick_o <= 1'b0;
    end
  end

endmodule

// ---- tb/tws_master_ctrl_sva.sv ----
// concurrent checks on the register port and line drivers of the two-wire master
`timescale 1ns/1ps
module tws_master_ctrl_sva (
  input wire logic                  clk_i,    // system clock
  input wire logic                  rst_n_i,  // sync reset, active low
  input wire tws_pkg::tws_wb_req_t  wb_req_i, // wishbone request
  input wire tws_pkg::tws_wb_rsp_t  wb_rsp_o, // wishbone answer
  input wire tws_pkg::tws_pin_in_t  pin_i,    // bus line levels
  input wire tws_pkg::tws_pin_out_t pin_o     // bus line drivers
);
  import tws_pkg::*;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);
  localparam int unsigned HALF_BIT = 2 * QUARTER_CYC - 1;
  logic [10:0] scl_cnt_q;

  // cycles since the clock driver last changed, saturating
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || $changed(pin_o.scl_oe_n)) begin
      scl_cnt_q <= '0;
    end else if (scl_cnt_q != '1) begin
      scl_cnt_q <= scl_cnt_q + 11'h001;
    end
  end

  sequence s_req;
    wb_req_i.cyc && wb_req_i.stb && !wb_rsp_o.ack;
  endsequence
  sequence s_ack_pulse;
    wb_rsp_o.ack ##1 !wb_rsp_o.ack;
  endsequence

  a_ack_next: assert property (s_req |=> s_ack_pulse)
    else $error("ack not a single pulse one cycle after request");
  a_ack_only_req: assert property (wb_rsp_o.ack |-> $past(wb_req_i.cyc && wb_req_i.stb))
    else $error("ack without request");
  a_rd_upper_zero: assert property (wb_rsp_o.ack |-> wb_rsp_o.dat[31:STAT_W] == '0)
    else $error("upper read data bits not zero");
  a_pins_low_only: assert property (!pin_o.scl_o && !pin_o.sda_o)
    else $error("line driver level not low");
  a_reset_release: assert property (disable iff (1'b0) !rst_n_i |=> pin_o.scl_oe_n && pin_o.sda_oe_n && !wb_rsp_o.ack)
    else $error("lines not released in reset");
  a_start_clk_high: assert property ($fell(pin_o.sda_oe_n) && $past(pin_o.scl_oe_n) |-> pin_o.scl_oe_n && pin_i.scl)
    else $error("data pulled low with clock high outside start");
  a_stop_clk_high: assert property ($rose(pin_o.sda_oe_n) && $past(pin_o.scl_oe_n) |-> pin_o.scl_oe_n && pin_i.scl)
    else $error("data released with clock high outside stop");
  a_clk_high_time: assert property ($fell(pin_o.scl_oe_n) |-> scl_cnt_q >= HALF_BIT)
    else $error("clock high phase shorter than half a bit");
  a_clk_low_time: assert property ($rose(pin_o.scl_oe_n) |-> scl_cnt_q >= HALF_BIT)
    else $error("clock low phase shorter than half a bit");
endmodule

// ---- tb/tws_port_model.sv ----
// behavioural serial port on the far side: slave receiver and transmitter
`timescale 1ns/1ps
module tws_port_model #(
  parameter logic [6:0] OWN_ADDR = 7'h2A  // own bus address, slave active beside the master
) (
  input  wire logic       clk_i,      // sampling clock
  input  wire logic       rst_n_i,    // sync reset, active low
  input  wire logic       scl_i,      // resolved clock line
  input  wire logic       sda_i,      // resolved data line
  input  wire logic [7:0] tx_byte_i,  // byte returned on reads
  input  wire logic       stretch_i,  // hold clock low after each fall
  output logic            scl_oe_n_o, // low pulls the clock line
  output logic            sda_oe_n_o, // low pulls the data line
  output logic [7:0]      rx_byte_o,  // last byte written to us
  output logic [7:0]      n_start_o,  // start conditions seen
  output logic [7:0]      n_stop_o    // stop conditions seen
);
  logic [1:0] scl_q, sda_q;
  logic [3:0] bit_q;
  logic [7:0] sh_q, tx_q;
  logic [9:0] hold_q;
  logic       sel_q, rd_q, adr_q, ack_q, rise, fall, start, stop;

  always_ff @(posedge clk_i) begin
    scl_q <= {scl_q[0], scl_i};
    sda_q <= {sda_q[0], sda_i};
  end
  assign rise  = !scl_q[1] && scl_q[0];
  assign fall  = scl_q[1] && !scl_q[0];
  assign start = scl_q[1] && scl_q[0] && sda_q[1] && !sda_q[0];
  assign stop  = scl_q[1] && scl_q[0] && !sda_q[1] && sda_q[0];

  // clock stretching after each falling edge
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      hold_q <= '0;
    end else if (fall && stretch_i) begin
      hold_q <= 10'h258;
    end else if (hold_q != '0) begin
      hold_q <= hold_q - 10'h001;
    end
  end
  assign scl_oe_n_o = (hold_q == '0);

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      {bit_q, sel_q, rd_q, adr_q, ack_q} <= '0;
      sda_oe_n_o <= 1'b1;
      {rx_byte_o, n_start_o, n_stop_o} <= '0;
    end else if (start) begin
      n_start_o  <= n_start_o + 8'h01;
      {bit_q, sel_q, adr_q} <= 6'h01;
      sda_oe_n_o <= 1'b1;
    end else if (stop) begin
      n_stop_o   <= n_stop_o + 8'h01;
      {sel_q, adr_q} <= 2'h0;
      sda_oe_n_o <= 1'b1;
    end else if (rise) begin
      bit_q <= bit_q + 4'h1;
      if (bit_q < 4'h8) sh_q <= {sh_q[6:0], sda_q[0]};
      else ack_q <= !sda_q[0];
    end else if (fall) begin // data moves only while the clock is low
      if (bit_q == 4'h8 && adr_q) begin
        sel_q      <= sh_q[7:1] == OWN_ADDR;
        rd_q       <= sh_q[0];
        adr_q      <= 1'b0;
        sda_oe_n_o <= sh_q[7:1] != OWN_ADDR;
      end else if (bit_q == 4'h8 && sel_q && !rd_q) begin
        rx_byte_o  <= sh_q;
        sda_oe_n_o <= 1'b0;
      end else if (bit_q == 4'h9) begin
        bit_q      <= 4'h0;
        sel_q      <= sel_q && !(rd_q && !ack_q);
        sda_oe_n_o <= !(sel_q && rd_q && ack_q) || tx_byte_i[7];
        tx_q       <= {tx_byte_i[6:0], 1'b0};
      end else if (bit_q != 4'h0 && sel_q && rd_q) begin
        sda_oe_n_o <= (bit_q == 4'h8) || tx_q[7];
        tx_q       <= {tx_q[6:0], 1'b0};
      end else begin
        sda_oe_n_o <= 1'b1;
      end
    end
  end
endmodule

// ---- tb/testbench.sv ----
// self-checking bench of the two-wire master: register tasks and bus transfers
`timescale 1ns/1ps
bind tws_master_ctrl tws_master_ctrl_sva tws_master_ctrl_sva_i (.clk_i(clk_i), .rst_n_i(rst_n_i),
  .wb_req_i(wb_req_i), .wb_rsp_o(wb_rsp_o), .pin_i(pin_i), .pin_o(pin_o));
module testbench;
  import tws_pkg::*;
  localparam logic [6:0] DEV_ADDR = 7'h2A;
  localparam logic [7:0] DEV_TX   = 8'h3C;
  localparam int         LIMIT    = 90000;
  logic         clk_i, rst_n_i, m_scl_oe_n, m_sda_oe_n, stretch, fight;
  tws_wb_req_t  wb_req;
  tws_wb_rsp_t  wb_rsp;
  tws_pin_in_t  pin_in;
  tws_pin_out_t pin_out;
  logic [7:0]   m_rx, m_starts, m_stops;
  logic [31:0]  rd;
  int           n_errors = 0;
  int           n_checks = 0;
  int           cyc_cnt  = 0;

  // wired-AND with pull-ups; a rival master pulls data low while fight is set
  assign pin_in.scl = pin_out.scl_oe_n & m_scl_oe_n;
  assign pin_in.sda = pin_out.sda_oe_n & m_sda_oe_n & ~fight;

  tws_master_ctrl tws_master_ctrl_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .wb_req_i(wb_req),
    .wb_rsp_o(wb_rsp), .pin_i(pin_in), .pin_o(pin_out));
  tws_port_model #(.OWN_ADDR(DEV_ADDR)) tws_port_model_i (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .scl_i(pin_in.scl), .sda_i(pin_in.sda), .tx_byte_i(DEV_TX), .stretch_i(stretch),
    .scl_oe_n_o(m_scl_oe_n), .sda_oe_n_o(m_sda_oe_n), .rx_byte_o(m_rx), .n_start_o(m_starts),
    .n_stop_o(m_stops));

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  always @(posedge clk_i) begin
    cyc_cnt++;
    if (cyc_cnt == LIMIT) begin
      n_errors++;
      final_report();
    end
  end

  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  function automatic logic [31:0] bitm(input int unsigned i);
    return 32'h1 << i;
  endfunction

  // one classic cycle; ack sampled at a rising edge, data taken and request released at that edge
  task automatic wb_xfer(input logic wr, input logic [7:0] adr, input logic [31:0] dat, input logic [3:0] sel);
    @(posedge clk_i);
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: wr, adr: adr, sel: sel, dat: dat};
    do @(posedge clk_i); while (wb_rsp.ack !== 1'b1);
    rd = wb_rsp.dat;
    wb_req <= '0;
  endtask

  task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
    wb_xfer(1'b1, adr, dat, 4'hF);
  endtask

  task automatic rdchk(input string what, input logic [7:0] adr, input logic [31:0] mask, input logic [31:0] exp);
    wb_xfer(1'b0, adr, 32'h0, 4'hF);
    check(what, rd & mask, exp);
  endtask

  // issue a command and poll until the sequencer is idle again
  task automatic cmd(input logic [31:0] c);
    int n;
    wr(REG_CMD, c);
    n = 0;
    do begin
      wb_xfer(1'b0, REG_STAT, 32'h0, 4'hF);
      n++;
    end while (rd[STAT_BUSY] !== 1'b0 && n < 20000);
    if (n >= 20000) n_errors++;
  endtask

  initial begin
    wb_req  = '0;
    rst_n_i = 1'b0;
    stretch = 1'b0;
    fight   = 1'b0;
    repeat (8) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    check("idle lines", {30'h0, pin_in.scl, pin_in.sda}, 32'h3);
    rdchk("ctrl reset", REG_CTRL, 32'hFFFFFFFF, {24'h0, CTRL_RST});
    rdchk("stat reset", REG_STAT, 32'hFFFFFFFF, 32'h0);
    wb_xfer(1'b1, REG_TXD, 32'h5A, 4'h0);
    rdchk("txd sel0 ignored", REG_TXD, 32'hFF, {24'h0, TXD_RST});
    wr(8'h20, 32'hFF);
    rdchk("unmapped", 8'h20, 32'hFFFFFFFF, 32'h0);
    $display("test reset done");
    wr(REG_CTRL, 32'h1);
    cmd(bitm(CMD_WRITE));
    rdchk("write unowned", REG_STAT, bitm(STAT_REFUSED) | bitm(STAT_OWN), bitm(STAT_REFUSED));
    wr(REG_STAT, 32'h1F0);
    $display("test refuse done");
    stretch <= 1'b1;
    wr(REG_TXD, {24'h0, DEV_ADDR, 1'b0});
    cmd(bitm(CMD_START) | bitm(CMD_WRITE));
    rdchk("addr write", REG_STAT, 32'h1FF, bitm(STAT_START_SN) | bitm(STAT_OWN) | bitm(STAT_DONE));
    wr(REG_TXD, 32'hA5);
    cmd(bitm(CMD_WRITE));
    check("slave rx", {24'h0, m_rx}, 32'hA5);
    check("single start", {24'h0, m_starts}, 32'h1);
    stretch <= 1'b0;
    $display("test write done");
    wr(REG_TXD, {24'h0, DEV_ADDR, 1'b1});
    cmd(bitm(CMD_START) | bitm(CMD_WRITE));
    cmd(bitm(CMD_READ) | bitm(CMD_NACK) | bitm(CMD_STOP));
    rdchk("read byte", REG_RXD, 32'hFF, {24'h0, DEV_TX});
    rdchk("after stop", REG_STAT, 32'h00F, bitm(STAT_STOP_SN));
    check("starts stops", {16'h0, m_starts, m_stops}, 32'h0201);
    $display("test read done");
    wr(REG_STAT, 32'h1F0);
    wr(REG_TXD, 32'h22);
    cmd(bitm(CMD_START) | bitm(CMD_WRITE) | bitm(CMD_STOP));
    rdchk("addr nack", REG_STAT, bitm(STAT_RX_NACK), bitm(STAT_RX_NACK));
    cmd(bitm(CMD_STOP));
    rdchk("released", REG_STAT, bitm(STAT_OWN) | bitm(STAT_BUSY), 32'h0);
    $display("test nack done");
    wr(REG_STAT, 32'h1F0);
    cmd(bitm(CMD_START));
    fight <= 1'b1;
    wr(REG_TXD, 32'hFF);
    cmd(bitm(CMD_WRITE));
    rdchk("arb lost", REG_STAT, bitm(STAT_ARB_ADDR) | bitm(STAT_OWN), bitm(STAT_ARB_ADDR));
    check("lines freed", {30'h0, pin_out.scl_oe_n, pin_out.sda_oe_n}, 32'h3);
    cmd(bitm(CMD_START));
    rdchk("busy bus", REG_STAT, bitm(STAT_REFUSED) | bitm(STAT_OWN), bitm(STAT_REFUSED));
    fight <= 1'b0;
    repeat (10) @(posedge clk_i);
    rdchk("stop seen", REG_STAT, bitm(STAT_STOP_SN), bitm(STAT_STOP_SN));
    wr(REG_CTRL, 32'h0);
    rdchk("disabled", REG_STAT, bitm(STAT_START_SN) | bitm(STAT_STOP_SN), 32'h0);
    $display("test arbitration done");
    final_report();
  end
endmodule
